// ---- verilog/gtbp_pkg.sv ----
package gtbp_pkg;

   // Pin counts and positions in the flat pin vector
   localparam int BANK_A_PINS = 8;
   localparam int BANK_B_PINS = 8;
   localparam int BANK_C_PINS = 6;
   localparam int PIN_COUNT   = 22;
   localparam int BANK_A_BASE = 0;
   localparam int BANK_B_BASE = 8;
   localparam int BANK_C_BASE = 16;

   // Register port widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [7:0] OFS_BANK_C_DATA_LATCH = 8'h00;
   localparam logic [7:0] OFS_BANK_C_DIRECTION  = 8'h01;
   localparam logic [7:0] OFS_BANK_C_OPTION     = 8'h02;
   localparam logic [7:0] OFS_BANK_B_DATA_LATCH = 8'h04;
   localparam logic [7:0] OFS_BANK_B_DIRECTION  = 8'h05;
   localparam logic [7:0] OFS_BANK_B_OPTION     = 8'h06;
   localparam logic [7:0] OFS_BANK_A_DATA_LATCH = 8'h08;
   localparam logic [7:0] OFS_BANK_A_DIRECTION  = 8'h09;
   localparam logic [7:0] OFS_BANK_A_OPTION     = 8'h0A;
   localparam logic [7:0] OFS_IRQ_POLARITY      = 8'h0C;

   // Reset values
   localparam logic [7:0] RST_PORT_REG     = 8'h00;
   localparam logic [7:0] RST_IRQ_POLARITY = 8'h00;
   localparam logic [7:0] READ_UNMAPPED    = 8'h00;

   // Polarity field positions in the polarity register
   localparam int POS_GROUP1_POLARITY_HI = 7;
   localparam int POS_GROUP1_POLARITY_LO = 6;
   localparam int POS_GROUP0_POLARITY_HI = 4;
   localparam int POS_GROUP0_POLARITY_LO = 3;
   localparam logic [7:0] IRQ_POLARITY_MASK = 8'hD8;

   // Which pins feed each interrupt group (bank A, banks B and C)
   localparam logic [21:0] GROUP0_PINS = 22'h0000FF;
   localparam logic [21:0] GROUP1_PINS = 22'h3FFF00;

   // Polarity selections {hi, lo}
   typedef enum logic [1:0] {
      GTBP_POL_FALL_LOW = 2'h0,
      GTBP_POL_RISE     = 2'h1,
      GTBP_POL_FALL     = 2'h2,
      GTBP_POL_BOTH     = 2'h3
   } gtbp_polarity_t;

endpackage

// ---- verilog/gtbp_sync.sv ----
`timescale 1ns/1ns
module gtbp_sync
#(
   parameter int WIDTH = 22
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   // First stage feeds only the second
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1   <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule

// ---- verilog/gtbp_pin_cell.sv ----
`timescale 1ns/1ns
module gtbp_pin_cell
#(
   parameter bit TRUE_OD = 1'b0,
   parameter bit HAS_OPT = 1'b1
)
(
   // Configuration
   input  wire logic dir,
   input  wire logic opt,
   input  wire logic latch,
   input  wire logic level,
   // Peripheral override
   input  wire logic alt_en,
   input  wire logic alt_val,
   input  wire logic alt_pp,
   // Pad controls
   output logic      drive_out,
   output logic      drive_oe,
   output logic      pull_en,
   output logic      high_side,
   output logic      irq_src,
   output logic      read_bit
);

   logic opt_eff;

   assign opt_eff = opt & HAS_OPT;

   always_comb
   begin
      drive_out = 1'b0;
      drive_oe  = 1'b0;
      pull_en   = 1'b0;
      high_side = 1'b0;
      irq_src   = 1'b0;
      if (alt_en)
      begin
         if (alt_pp)
         begin
            drive_out = alt_val;
            drive_oe  = 1'b1;
            high_side = 1'b1;
         end
         else
         begin
            drive_oe = ~alt_val;
         end
      end
      else if (dir)
      begin
         if (opt_eff && !TRUE_OD)
         begin
            drive_out = latch;
            drive_oe  = 1'b1;
            high_side = 1'b1;
         end
         else
         begin
            drive_oe = ~latch;
         end
      end
      else
      begin
         // Pull-up only on banks B and C
         pull_en = opt_eff & ~TRUE_OD;
         irq_src = opt_eff;
      end
   end

   assign read_bit = dir ? latch : level;

endmodule

// ---- verilog/gtbp_top.sv ----
`timescale 1ns/1ns
// Summary of operation
// - Direction bit: 0 input, 1 output
// - Input pins read the live pin level
// - Output pins drive and read the latch
// - Latch writes always stored
// - Output pins never request interrupts
// - Group requests ORed, low pin masks others
// - Input option: 0 floating, 1 interrupt
// - Banks B, C output: open drain/push-pull
// - Bank A output: open drain, 1 reserved
// - No option bit: direction alone decides
// - All registers reset to zero
// - Peripheral output overrides pin control
// - Peripheral input readable via latch read
// - Two-bit polarity per group selects event
module gtbp_top
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Pins
   input  wire logic [21:0] pad_in,
   output logic      [21:0] pad_out,
   output logic      [21:0] pad_oe,
   output logic      [21:0] pad_pullup,
   output logic      [21:0] pad_high_side,
   // Peripheral alternate functions
   input  wire logic [21:0] alt_out_en,
   input  wire logic [21:0] alt_out_val,
   input  wire logic [21:0] alt_push_pull,
   output logic      [21:0] alt_in,
   // Analog converter routing
   input  wire logic [21:0] adc_select,
   output logic      [21:0] adc_switch,
   // External interrupt lines
   output logic             ext_irq_group0,
   output logic             ext_irq_group1
);

   // Port registers
   logic [7:0]  bank_a_data_latch;
   logic [7:0]  bank_a_direction;
   logic [7:0]  bank_a_option;
   logic [7:0]  bank_b_data_latch;
   logic [7:0]  bank_b_direction;
   logic [7:0]  bank_b_option;
   logic [7:0]  bank_c_data_latch;
   logic [7:0]  bank_c_direction;
   logic [7:0]  bank_c_option;
   logic [7:0]  irq_polarity;

   // Flat per-pin views
   logic [21:0] pin_dir;
   logic [21:0] pin_opt;
   logic [21:0] pin_latch;
   logic [21:0] pin_level;
   logic [21:0] cell_out;
   logic [21:0] cell_oe;
   logic [21:0] cell_pullup;
   logic [21:0] cell_high;
   logic [21:0] cell_irq;
   logic [21:0] cell_read;

   // Interrupt group tracking
   logic        group0_line;
   logic        group1_line;
   logic        group0_prev;
   logic        group1_prev;
   logic        next_irq0;
   logic        next_irq1;
   logic [7:0]  next_rdata;

   assign pin_dir   = {bank_c_direction[5:0], bank_b_direction,
                       bank_a_direction};
   assign pin_opt   = {bank_c_option[5:0], bank_b_option,
                       bank_a_option};
   assign pin_latch = {bank_c_data_latch[5:0], bank_b_data_latch,
                       bank_a_data_latch};

   gtbp_sync
   #(
      .WIDTH (gtbp_pkg::PIN_COUNT)
   )
   u_sync
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in (pad_in),
      .sync_out (pin_level)
   );

   genvar g;
   generate
      for (g = 0; g < gtbp_pkg::PIN_COUNT; g = g + 1)
      begin : g_pin
         gtbp_pin_cell
         #(
            .TRUE_OD (g < gtbp_pkg::BANK_B_BASE),
            .HAS_OPT (1'b1)
         )
         u_cell
         (
            .dir       (pin_dir[g]),
            .opt       (pin_opt[g]),
            .latch     (pin_latch[g]),
            .level     (pin_level[g]),
            .alt_en    (alt_out_en[g]),
            .alt_val   (alt_out_val[g]),
            .alt_pp    (alt_push_pull[g]),
            .drive_out (cell_out[g]),
            .drive_oe  (cell_oe[g]),
            .pull_en   (cell_pullup[g]),
            .high_side (cell_high[g]),
            .irq_src   (cell_irq[g]),
            .read_bit  (cell_read[g])
         );
      end
   endgenerate

   // Bank C registers
   // Everything clears to zero
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bank_c_data_latch <= gtbp_pkg::RST_PORT_REG;
         bank_c_direction  <= gtbp_pkg::RST_PORT_REG;
         bank_c_option     <= gtbp_pkg::RST_PORT_REG;
      end
      else if (reg_wr)
      begin
         if (reg_addr == gtbp_pkg::OFS_BANK_C_DATA_LATCH)
            bank_c_data_latch <= reg_wdata;
         else if (reg_addr == gtbp_pkg::OFS_BANK_C_DIRECTION)
            bank_c_direction <= reg_wdata;
         else if (reg_addr == gtbp_pkg::OFS_BANK_C_OPTION)
            bank_c_option <= reg_wdata;
      end
   end

   // Bank B registers
   // Cleared to floating inputs
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bank_b_data_latch <= gtbp_pkg::RST_PORT_REG;
         bank_b_direction  <= gtbp_pkg::RST_PORT_REG;
         bank_b_option     <= gtbp_pkg::RST_PORT_REG;
      end
      else if (reg_wr)
      begin
         if (reg_addr == gtbp_pkg::OFS_BANK_B_DATA_LATCH)
            bank_b_data_latch <= reg_wdata;
         else if (reg_addr == gtbp_pkg::OFS_BANK_B_DIRECTION)
            bank_b_direction <= reg_wdata;
         else if (reg_addr == gtbp_pkg::OFS_BANK_B_OPTION)
            bank_b_option <= reg_wdata;
      end
   end

   // Bank A registers
   // Cleared to floating inputs
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bank_a_data_latch <= gtbp_pkg::RST_PORT_REG;
         bank_a_direction  <= gtbp_pkg::RST_PORT_REG;
         bank_a_option     <= gtbp_pkg::RST_PORT_REG;
      end
      else if (reg_wr)
      begin
         if (reg_addr == gtbp_pkg::OFS_BANK_A_DATA_LATCH)
            bank_a_data_latch <= reg_wdata;
         else if (reg_addr == gtbp_pkg::OFS_BANK_A_DIRECTION)
            bank_a_direction <= reg_wdata;
         else if (reg_addr == gtbp_pkg::OFS_BANK_A_OPTION)
            bank_a_option <= reg_wdata;
      end
   end

   // Interrupt polarity; spare bits are never stored
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_polarity <= gtbp_pkg::RST_IRQ_POLARITY;
      else if (reg_wr && reg_addr == gtbp_pkg::OFS_IRQ_POLARITY)
         irq_polarity <= reg_wdata & gtbp_pkg::IRQ_POLARITY_MASK;
   end

   // Read mux; bank C bits with no pin return the stored latch
   always_comb
   begin
      next_rdata = gtbp_pkg::READ_UNMAPPED;
      if (reg_addr == gtbp_pkg::OFS_BANK_C_DATA_LATCH)
         next_rdata = {bank_c_data_latch[7:6],
                       cell_read[gtbp_pkg::BANK_C_BASE +: 6]};
      else if (reg_addr == gtbp_pkg::OFS_BANK_C_DIRECTION)
         next_rdata = bank_c_direction;
      else if (reg_addr == gtbp_pkg::OFS_BANK_C_OPTION)
         next_rdata = bank_c_option;
      else if (reg_addr == gtbp_pkg::OFS_BANK_B_DATA_LATCH)
         next_rdata = cell_read[gtbp_pkg::BANK_B_BASE +: 8];
      else if (reg_addr == gtbp_pkg::OFS_BANK_B_DIRECTION)
         next_rdata = bank_b_direction;
      else if (reg_addr == gtbp_pkg::OFS_BANK_B_OPTION)
         next_rdata = bank_b_option;
      else if (reg_addr == gtbp_pkg::OFS_BANK_A_DATA_LATCH)
         next_rdata = cell_read[gtbp_pkg::BANK_A_BASE +: 8];
      else if (reg_addr == gtbp_pkg::OFS_BANK_A_DIRECTION)
         next_rdata = bank_a_direction;
      else if (reg_addr == gtbp_pkg::OFS_BANK_A_OPTION)
         next_rdata = bank_a_option;
      else if (reg_addr == gtbp_pkg::OFS_IRQ_POLARITY)
         next_rdata = irq_polarity;
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= gtbp_pkg::READ_UNMAPPED;
      else if (reg_rd)
         reg_rdata <= next_rdata;
      else
         reg_rdata <= gtbp_pkg::READ_UNMAPPED;
   end

   // Pad drivers registered so no glitch reaches the pins
   // Override applied per pin
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pad_out       <= '0;
         pad_oe        <= '0;
         pad_pullup    <= '0;
         pad_high_side <= '0;
      end
      else
      begin
         pad_out       <= cell_out;
         pad_oe        <= cell_oe;
         pad_pullup    <= cell_pullup;
         pad_high_side <= cell_high;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         alt_in <= '0;
      else
         alt_in <= pin_level;
   end

   // Converter owns the mux; a floating input is its job
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         adc_switch <= '0;
      else
         adc_switch <= adc_select;
   end

   // Wired-AND line: any enabled low pin pulls it low
   // Output pins never enabled as sources
   assign group0_line = &(pin_level | ~(cell_irq & gtbp_pkg::GROUP0_PINS));
   assign group1_line = &(pin_level | ~(cell_irq & gtbp_pkg::GROUP1_PINS));

   // Previous line level for edge detection
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         group0_prev <= 1'b1;
         group1_prev <= 1'b1;
      end
      else
      begin
         group0_prev <= group0_line;
         group1_prev <= group1_line;
      end
   end

   // Polarity selects level or edge event
   always_comb
   begin
      case (gtbp_pkg::gtbp_polarity_t'(
              {irq_polarity[gtbp_pkg::POS_GROUP0_POLARITY_HI],
               irq_polarity[gtbp_pkg::POS_GROUP0_POLARITY_LO]}))
         gtbp_pkg::GTBP_POL_FALL_LOW: next_irq0 = ~group0_line;
         gtbp_pkg::GTBP_POL_FALL:     next_irq0 = group0_prev & ~group0_line;
         gtbp_pkg::GTBP_POL_RISE:     next_irq0 = ~group0_prev & group0_line;
         default:                     next_irq0 = group0_prev ^ group0_line;
      endcase
      case (gtbp_pkg::gtbp_polarity_t'(
              {irq_polarity[gtbp_pkg::POS_GROUP1_POLARITY_HI],
               irq_polarity[gtbp_pkg::POS_GROUP1_POLARITY_LO]}))
         gtbp_pkg::GTBP_POL_FALL_LOW: next_irq1 = ~group1_line;
         gtbp_pkg::GTBP_POL_FALL:     next_irq1 = group1_prev & ~group1_line;
         gtbp_pkg::GTBP_POL_RISE:     next_irq1 = ~group1_prev & group1_line;
         default:                     next_irq1 = group1_prev ^ group1_line;
      endcase
   end

   // Edge events are one-cycle pulses; low-level mode holds
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ext_irq_group0 <= 1'b0;
      else
         ext_irq_group0 <= next_irq0;
   end

   // Group 1 request, same timing as group 0
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ext_irq_group1 <= 1'b0;
      else
         ext_irq_group1 <= next_irq1;
   end

endmodule

// ---- test/gtbp_top_monitor.sv ----
`timescale 1ns/1ns
module gtbp_top_monitor
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // Pins
   input wire logic [21:0] pad_in,
   input wire logic [21:0] pad_out,
   input wire logic [21:0] pad_oe,
   input wire logic [21:0] pad_pullup,
   input wire logic [21:0] pad_high_side,
   // Peripheral override
   input wire logic [21:0] alt_out_en,
   input wire logic [21:0] alt_out_val,
   input wire logic [21:0] alt_push_pull,
   // Requests
   input wire logic        ext_irq_group0,
   input wire logic        ext_irq_group1
);
   // Edges seen with every pin of a group high
   logic [3:0] quiet0;
   logic [3:0] quiet1;

   default clocking mon_cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         quiet0 <= 4'h0;
      else if (pad_in[7:0] != 8'hFF)
         quiet0 <= 4'h0;
      else if (quiet0 != 4'h8)
         quiet0 <= quiet0 + 4'h1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         quiet1 <= 4'h0;
      else if (pad_in[21:8] != 14'h3FFF)
         quiet1 <= 4'h0;
      else if (quiet1 != 4'h8)
         quiet1 <= quiet1 + 4'h1;
   end

   // Margin of six covers the sync chain and the request flop
   property p_quiet0;
      quiet0 >= 4'h6 |-> !ext_irq_group0;
   endproperty
   a_quiet0: assert property (p_quiet0)
      else $error("group0 request while its pins sat high");

   property p_quiet1;
      quiet1 >= 4'h6 |-> !ext_irq_group1;
   endproperty
   a_quiet1: assert property (p_quiet1)
      else $error("group1 request while its pins sat high");

   property p_reset;
      $rose(rst_n) |-> (pad_oe | pad_pullup | pad_high_side) == 22'h0
         && !ext_irq_group0 && !ext_irq_group1;
   endproperty
   a_reset: assert property (p_reset)
      else $error("pins not idle after reset");

   property p_pull_excl;
      (pad_pullup & (pad_oe | pad_high_side)) == 22'h0;
   endproperty
   a_pull_excl: assert property (p_pull_excl)
      else $error("pull-up on a driven pin");

   property p_bank_a_pull;
      pad_pullup[7:0] == 8'h00;
   endproperty
   a_bank_a_pull: assert property (p_bank_a_pull)
      else $error("pull-up on bank a");

   property p_bank_a_hs;
      (pad_high_side[7:0]
         & ~$past(alt_out_en[7:0] & alt_push_pull[7:0])) == 8'h00;
   endproperty
   a_bank_a_hs: assert property (p_bank_a_hs)
      else $error("high side on bank a");

   property p_alt_pp;
      ($past(alt_out_en & alt_push_pull) & ~(pad_oe & pad_high_side
         & ~(pad_out ^ $past(alt_out_val)))) == 22'h0;
   endproperty
   a_alt_pp: assert property (p_alt_pp)
      else $error("peripheral push-pull not driven");

   property p_alt_od;
      ($past(alt_out_en & ~alt_push_pull) & (pad_out | pad_high_side
         | ~(pad_oe ^ $past(alt_out_val)))) == 22'h0;
   endproperty
   a_alt_od: assert property (p_alt_od)
      else $error("peripheral open drain wrong");
endmodule

bind gtbp_top gtbp_top_monitor i_mon
(
   .clk           (clk),
   .rst_n         (rst_n),
   .pad_in        (pad_in),
   .pad_out       (pad_out),
   .pad_oe        (pad_oe),
   .pad_pullup    (pad_pullup),
   .pad_high_side (pad_high_side),
   .alt_out_en    (alt_out_en),
   .alt_out_val   (alt_out_val),
   .alt_push_pull (alt_push_pull),
   .ext_irq_group0(ext_irq_group0),
   .ext_irq_group1(ext_irq_group1)
);

// ---- test/gtbp_board.sv ----
`timescale 1ns/1ns
module gtbp_board
(
   // Clock
   input  wire logic        clk,
   // Device pad controls
   input  wire logic [21:0] pad_out,
   input  wire logic [21:0] pad_oe,
   input  wire logic [21:0] pad_pullup,
   // Board drivers
   input  wire logic [21:0] ext_en,
   input  wire logic [21:0] ext_val,
   // Resolved level
   output logic      [21:0] pad_level
);
   // Undriven pins wander so a stale level never passes
   logic flip = 1'b0;

   always @(posedge clk)
      flip <= ~flip;

   assign pad_level = (pad_oe & pad_out)
      | (~pad_oe & ext_en & ext_val)
      | (~pad_oe & ~ext_en & (pad_pullup | {22{flip}}));
endmodule

// ---- test/gtbp_top_tb_top.sv ----
`timescale 1ns/1ns
module gtbp_top_tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_rdata;
   logic [21:0] pad_in;
   logic [21:0] pad_out;
   logic [21:0] pad_oe;
   logic [21:0] pad_pullup;
   logic [21:0] pad_high_side;
   logic [21:0] alt_out_en = 22'h0;
   logic [21:0] alt_out_val = 22'h0;
   logic [21:0] alt_push_pull = 22'h0;
   logic [21:0] alt_in;
   logic [21:0] adc_select = 22'h0;
   logic [21:0] adc_switch;
   logic        irq0;
   logic        irq1;
   logic [21:0] ext_en = 22'h0;
   logic [21:0] ext_val = 22'h0;
   int          bad_count = 0;
   int          total_checks = 0;
   int          cycles = 0;
   logic [7:0]  offs [9] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05,
                             8'h06, 8'h08, 8'h09, 8'h0A};

   gtbp_top i_dut
   (
      .clk           (clk),
      .rst_n         (rst_n),
      .reg_addr      (reg_addr),
      .reg_wdata     (reg_wdata),
      .reg_wr        (reg_wr),
      .reg_rd        (reg_rd),
      .reg_rdata     (reg_rdata),
      .pad_in        (pad_in),
      .pad_out       (pad_out),
      .pad_oe        (pad_oe),
      .pad_pullup    (pad_pullup),
      .pad_high_side (pad_high_side),
      .alt_out_en    (alt_out_en),
      .alt_out_val   (alt_out_val),
      .alt_push_pull (alt_push_pull),
      .alt_in        (alt_in),
      .adc_select    (adc_select),
      .adc_switch    (adc_switch),
      .ext_irq_group0(irq0),
      .ext_irq_group1(irq1)
   );

   gtbp_board i_board
   (
      .clk       (clk),
      .pad_out   (pad_out),
      .pad_oe    (pad_oe),
      .pad_pullup(pad_pullup),
      .ext_en    (ext_en),
      .ext_val   (ext_val),
      .pad_level (pad_in)
   );

   initial
      forever #4 clk = ~clk;

   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         bad_count++;
         finish_test;
      end
   end

   task automatic chk(input string what, input logic [21:0] seen,
                      input logic [21:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk("read data", {14'h0, reg_rdata}, {14'h0, e});
   endtask

   task automatic do_reset;
      @(posedge clk);
      rst_n      <= 1'b0;
      alt_out_en <= 22'h0;
      adc_select <= 22'h0;
      ext_en     <= 22'h0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
   endtask

   task automatic t_reset_regs;
      ext_en  <= 22'h3FFFFF;
      ext_val <= 22'h0;
      cyc(4);
      foreach (offs[i])
         rd(offs[i], 8'h00);
      rd(8'h03, 8'h00);
   endtask

   task automatic t_in_out;
      do_reset;
      ext_en  <= 22'h00FF00;
      ext_val <= 22'h00F000;
      wr(8'h04, 8'h5A);
      wr(8'h06, 8'hFF);
      wr(8'h0A, 8'hFF);
      cyc(4);
      chk("pull-ups", pad_pullup, 22'h00FF00);
      rd(8'h04, 8'hF0);
      chk("peripheral in", alt_in & 22'h00FF00, 22'h00F000);
      wr(8'h05, 8'hFF);
      ext_en <= 22'h0;
      cyc(3);
      chk("oe", pad_oe, 22'h00FF00);
      chk("high side", pad_high_side, 22'h00FF00);
      chk("out", pad_out & 22'h00FF00, 22'h005A00);
      rd(8'h04, 8'h5A);
   endtask

   task automatic t_open_drain;
      do_reset;
      wr(8'h00, 8'hD5);
      wr(8'h01, 8'h3F);
      wr(8'h08, 8'h0F);
      wr(8'h0A, 8'hFF);
      wr(8'h09, 8'hFF);
      cyc(3);
      chk("oe", pad_oe, 22'h2A00F0);
      chk("out", pad_out, 22'h0);
      chk("high side", pad_high_side, 22'h0);
      rd(8'h00, 8'hD5);
   endtask

   task automatic t_alt;
      do_reset;
      alt_out_en    <= 22'h00001C;
      alt_push_pull <= 22'h000004;
      alt_out_val   <= 22'h00000C;
      adc_select    <= 22'h050000;
      cyc(2);
      chk("oe", pad_oe, 22'h000014);
      chk("out", pad_out, 22'h000004);
      chk("high side", pad_high_side, 22'h000004);
      chk("converter", adc_switch, 22'h050000);
   endtask

   task automatic t_irq(input logic [1:0] mode, input bit mask,
                        input bit drive, input int exp);
      int n;
      do_reset;
      // Other pins held high, pin 9 low when mask is set, so idle groups must stay silent
      ext_en  <= {13'h1FFF, ~drive, 8'hFF};
      ext_val <= {12'hFFF, ~mask, 1'b1, 8'hFF};
      wr(8'h0C, {mode, 6'h00});
      wr(8'h06, {6'h00, mask, 1'b1});
      wr(8'h05, {7'h00, drive});
      cyc(8);
      n = 0;
      for (int i = 0; i < 40; i++)
      begin
         if (i == 5)
            ext_val[8] <= 1'b0;
         if (i == 20)
            ext_val[8] <= 1'b1;
         cyc(1);
         n += int'(irq1 === 1'b1);
      end
      chk("request cycles", 22'(n), 22'(exp));
   endtask

   task automatic t_irq0;
      do_reset;
      ext_en  <= 22'h0000FF;
      ext_val <= 22'h0000FF;
      // Group 0 falling edge only; spare bits must drop
      wr(8'h0C, 8'h37);
      rd(8'h0C, 8'h10);
      wr(8'h0A, 8'h01);
      cyc(8);
      chk("group0 idle", {21'h0, irq0}, 22'h0);
      @(posedge clk);
      ext_val <= 22'h0000FE;
      cyc(3);
      chk("group0 fall", {21'h0, irq0}, 22'h1);
      cyc(1);
      chk("group0 pulse", {21'h0, irq0}, 22'h0);
   endtask

   initial
   begin
      do_reset;
      t_reset_regs;
      t_in_out;
      t_open_drain;
      t_alt;
      t_irq(2'h0, 1'b0, 1'b0, 15);
      t_irq(2'h2, 1'b0, 1'b0, 1);
      t_irq(2'h1, 1'b0, 1'b0, 1);
      t_irq(2'h3, 1'b0, 1'b0, 2);
      t_irq(2'h2, 1'b1, 1'b0, 0);
      t_irq(2'h0, 1'b0, 1'b1, 0);
      t_irq0;
      finish_test;
   end
endmodule
